/* sdc_pkg.sv */
// Constants and types shared by the DRAM command and clock-gate state block.
package sdc_pkg;

    // Address and bank field layout.
    localparam int ADDR_W        = 12;
    localparam int COL_W         = 8;
    localparam int BANK_W        = 2;
    localparam int NUM_BANKS     = 4;
    localparam int AP_BIT        = 10;

    // Cycle delays.
    localparam int READ_MASK_LAT = 2;

    // Burst and exit timing defaults.
    localparam int BURST_LEN_DEF = 4;
    localparam int EXIT_WAIT_DEF = 2;

    // Reset values.
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
    localparam logic [ADDR_W-1:0] ROW_RST  = 12'h000;

    // Commands decoded from {row, column, write} strobes when selected.
    typedef enum logic [3:0] {
        SDC_CMD_INHIBIT = 4'h0,
        SDC_CMD_NOP     = 4'h1,
        SDC_CMD_ACT     = 4'h2,
        SDC_CMD_READ    = 4'h3,
        SDC_CMD_WRITE   = 4'h4,
        SDC_CMD_BST     = 4'h5,
        SDC_CMD_PRE     = 4'h6,
        SDC_CMD_REF     = 4'h7,
        SDC_CMD_LMR     = 4'h8
    } sdc_cmd_t;

    // Device-wide clock-gate state.
    typedef enum logic [2:0] {
        SDC_PWR_RUN     = 3'b000,
        SDC_PWR_PDOWN   = 3'b001,
        SDC_PWR_SELFREF = 3'b010,
        SDC_PWR_SUSPEND = 3'b011,
        SDC_PWR_SREXIT  = 3'b100
    } sdc_pwr_t;

    // Per-bank state.
    typedef enum logic [2:0] {
        SDC_BANK_IDLE   = 3'b000,
        SDC_BANK_ACTIVE = 3'b001,
        SDC_BANK_READ   = 3'b010,
        SDC_BANK_WRITE  = 3'b011,
        SDC_BANK_RDAP   = 3'b100,
        SDC_BANK_WRAP   = 3'b101
    } sdc_bank_t;

endpackage : sdc_pkg

/* sdc_core.sv */
// Command decoder, bank tracker and clock-gate state machine of the DRAM device.
`timescale 1ns/100ps
`default_nettype none

module sdc_core
    import sdc_pkg::*;
#(
    parameter int BURST_LEN = BURST_LEN_DEF,
    parameter int EXIT_WAIT = EXIT_WAIT_DEF
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        resetn,
    // Command pins
    input  wire logic                        clk_gate,
    input  wire logic                        chip_sel_n,
    input  wire logic                        row_strobe_n,
    input  wire logic                        col_strobe_n,
    input  wire logic                        write_strobe_n,
    input  wire logic                        bank_select_low,
    input  wire logic                        bank_select_high,
    input  wire logic [ADDR_W-1:0]           addr,
    input  wire logic                        byte_mask,
    // Data lines
    input  wire logic                        dq_in_valid,
    // Decoded actions toward the array
    output logic                             wr_strobe,
    output logic [BANK_W-1:0]                wr_bank,
    output logic [COL_W-1:0]                 wr_col,
    output logic                             rd_drive_en,
    output logic                             refresh_pulse,
    output logic [ADDR_W-1:0]                refresh_row,
    // State visible to the array
    output logic [ADDR_W-1:0]                mode_reg,
    output logic [NUM_BANKS*ADDR_W-1:0]      open_rows,
    output logic [NUM_BANKS-1:0]             bank_open,
    output logic [2:0]                       pwr_state,
    output logic                             all_idle
);

    // Two-stage synchronisers on every pin except dq_in_valid.
    localparam int PIN_W = ADDR_W + 8;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [PIN_W-1:0] pin_s1_nxt;

    always_comb begin
        pin_s1_nxt = {clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
                      bank_select_high, bank_select_low, byte_mask, addr};
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s1_r;
        end
    end

    logic              gate_now;
    logic              cs_n;
    logic [2:0]        strobes;
    logic [BANK_W-1:0] bank_sel;
    logic              mask_now;
    logic [ADDR_W-1:0] addr_now;
    logic              dq_valid_s;

    assign {gate_now, cs_n, strobes, bank_sel, mask_now, addr_now} = pin_s2_r;
    assign dq_valid_s = dq_in_valid;

    // Command decode.
    sdc_cmd_t cmd;
    always_comb begin
        if (cs_n) begin
            cmd = SDC_CMD_INHIBIT;
        end else begin
            unique case (strobes)
                3'b111: cmd = SDC_CMD_NOP;
                3'b011: cmd = SDC_CMD_ACT;
                3'b101: cmd = SDC_CMD_READ;
                3'b100: cmd = SDC_CMD_WRITE;
                3'b110: cmd = SDC_CMD_BST;
                3'b010: cmd = SDC_CMD_PRE;
                3'b001: cmd = SDC_CMD_REF;
                3'b000: cmd = SDC_CMD_LMR;
            endcase
        end
    end

    logic is_nop;
    assign is_nop = (cmd == SDC_CMD_INHIBIT) || (cmd == SDC_CMD_NOP);

    // State registers.
    sdc_pwr_t              pwr_r, pwr_nxt;
    sdc_bank_t             bank_r   [NUM_BANKS];
    sdc_bank_t             bank_nxt [NUM_BANKS];
    logic [ADDR_W-1:0]     row_r    [NUM_BANKS];
    logic [ADDR_W-1:0]     row_nxt  [NUM_BANKS];
    logic                  gate_prev_r, gate_prev_nxt;
    logic [ADDR_W-1:0]     mode_r, mode_nxt;
    logic [ADDR_W-1:0]     ref_cnt_r, ref_cnt_nxt;
    logic [7:0]            burst_cnt_r, burst_cnt_nxt;
    logic [BANK_W-1:0]     burst_bank_r, burst_bank_nxt;
    logic [COL_W-1:0]      col_r, col_nxt;
    logic [7:0]            exit_cnt_r, exit_cnt_nxt;
    logic [READ_MASK_LAT-1:0] mask_pipe_r, mask_pipe_nxt;
    logic                  burst_on;
    logic                  banks_idle;
    logic                  run;

    always_comb begin
        banks_idle = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (bank_r[b] != SDC_BANK_IDLE) begin
                banks_idle = 1'b0;
            end
        end
    end

    assign burst_on = (burst_cnt_r != 8'h00);
    // Commands count only with the gate high at this and the previous edge.
    assign run = (pwr_r == SDC_PWR_RUN) && gate_prev_r && gate_now;

    always_comb begin
        pwr_nxt        = pwr_r;
        gate_prev_nxt  = gate_now;
        mode_nxt       = mode_r;
        ref_cnt_nxt    = ref_cnt_r;
        burst_cnt_nxt  = burst_cnt_r;
        burst_bank_nxt = burst_bank_r;
        col_nxt        = col_r;
        exit_cnt_nxt   = exit_cnt_r;
        mask_pipe_nxt  = {mask_pipe_r[READ_MASK_LAT-2:0], mask_now};
        for (int b = 0; b < NUM_BANKS; b++) begin
            bank_nxt[b] = bank_r[b];
            row_nxt[b]  = row_r[b];
        end

        // Burst progress; auto precharge closes the bank at the end.
        if (run && burst_on) begin
            burst_cnt_nxt = burst_cnt_r - 8'h01;
            col_nxt       = col_r + 8'h01;
            if (burst_cnt_r == 8'h01) begin
                unique case (bank_r[burst_bank_r])
                    SDC_BANK_RDAP, SDC_BANK_WRAP: bank_nxt[burst_bank_r] = SDC_BANK_IDLE;
                    SDC_BANK_READ, SDC_BANK_WRITE: bank_nxt[burst_bank_r] = SDC_BANK_ACTIVE;
                    default: ;
                endcase
            end
        end

        unique case (pwr_r)
            SDC_PWR_RUN: begin
                if (gate_prev_r && !gate_now) begin
                    // Falling gate chooses the low-power mode.
                    if (burst_on) begin
                        pwr_nxt = SDC_PWR_SUSPEND;
                    end else if (banks_idle && cmd == SDC_CMD_REF) begin
                        pwr_nxt     = SDC_PWR_SELFREF;
                        ref_cnt_nxt = ref_cnt_r + 12'h001;
                    end else if (banks_idle && is_nop) begin
                        pwr_nxt = SDC_PWR_PDOWN;
                    end
                end else if (run) begin
                    unique case (cmd)
                        SDC_CMD_LMR: mode_nxt = addr_now;
                        SDC_CMD_REF: ref_cnt_nxt = ref_cnt_r + 12'h001;
                        SDC_CMD_ACT: begin
                            bank_nxt[bank_sel] = SDC_BANK_ACTIVE;
                            row_nxt[bank_sel]  = addr_now;
                        end
                        SDC_CMD_READ, SDC_CMD_WRITE: begin
                            // A new column command replaces any burst.
                            if (burst_on && burst_bank_r != bank_sel
                                && bank_r[burst_bank_r] inside {SDC_BANK_RDAP, SDC_BANK_WRAP}) begin
                                bank_nxt[burst_bank_r] = SDC_BANK_IDLE;
                            end else if (burst_on && burst_bank_r != bank_sel) begin
                                bank_nxt[burst_bank_r] = SDC_BANK_ACTIVE;
                            end
                            if (cmd == SDC_CMD_READ) begin
                                bank_nxt[bank_sel] = addr_now[AP_BIT] ? SDC_BANK_RDAP
                                                                      : SDC_BANK_READ;
                            end else begin
                                bank_nxt[bank_sel] = addr_now[AP_BIT] ? SDC_BANK_WRAP
                                                                      : SDC_BANK_WRITE;
                            end
                            burst_bank_nxt = bank_sel;
                            col_nxt        = addr_now[COL_W-1:0] + 8'h01;
                            burst_cnt_nxt  = 8'(BURST_LEN);
                        end
                        SDC_CMD_BST: begin
                            if (burst_on && bank_r[burst_bank_r] inside
                                {SDC_BANK_READ, SDC_BANK_WRITE}) begin
                                bank_nxt[burst_bank_r] = SDC_BANK_ACTIVE;
                            end
                            burst_cnt_nxt = 8'h00;
                        end
                        SDC_CMD_PRE: begin
                            // Precharge truncates a burst in the affected bank.
                            for (int b = 0; b < NUM_BANKS; b++) begin
                                if (addr_now[AP_BIT] || bank_sel == BANK_W'(b)) begin
                                    bank_nxt[b] = SDC_BANK_IDLE;
                                    if (burst_on && burst_bank_r == BANK_W'(b)) begin
                                        burst_cnt_nxt = 8'h00;
                                    end
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end
            SDC_PWR_PDOWN: begin
                if (gate_now && is_nop) begin
                    pwr_nxt = SDC_PWR_RUN;
                end
            end
            SDC_PWR_SELFREF: begin
                // Keep refreshing internally while the gate stays low.
                ref_cnt_nxt = ref_cnt_r + 12'h001;
                if (gate_now) begin
                    pwr_nxt      = SDC_PWR_SREXIT;
                    exit_cnt_nxt = 8'(EXIT_WAIT);
                end
            end
            SDC_PWR_SREXIT: begin
                // Commands are ignored until the exit time is spent.
                if (exit_cnt_r == 8'h01) begin
                    pwr_nxt = SDC_PWR_RUN;
                end
                exit_cnt_nxt = exit_cnt_r - 8'h01;
            end
            SDC_PWR_SUSPEND: begin
                if (gate_now) begin
                    pwr_nxt = SDC_PWR_RUN;
                end
            end
            default: pwr_nxt = SDC_PWR_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pwr_r        <= SDC_PWR_RUN;
            gate_prev_r  <= 1'b1;
            mode_r       <= MODE_RST;
            ref_cnt_r    <= ROW_RST;
            burst_cnt_r  <= 8'h00;
            burst_bank_r <= '0;
            col_r        <= '0;
            exit_cnt_r   <= 8'h00;
            mask_pipe_r  <= '1;
            for (int b = 0; b < NUM_BANKS; b++) begin
                bank_r[b] <= SDC_BANK_IDLE;
                row_r[b]  <= ROW_RST;
            end
        end else begin
            pwr_r        <= pwr_nxt;
            gate_prev_r  <= gate_prev_nxt;
            mode_r       <= mode_nxt;
            ref_cnt_r    <= ref_cnt_nxt;
            burst_cnt_r  <= burst_cnt_nxt;
            burst_bank_r <= burst_bank_nxt;
            col_r        <= col_nxt;
            exit_cnt_r   <= exit_cnt_nxt;
            mask_pipe_r  <= mask_pipe_nxt;
            for (int b = 0; b < NUM_BANKS; b++) begin
                bank_r[b] <= bank_nxt[b];
                row_r[b]  <= row_nxt[b];
            end
        end
    end

    // Registered outputs.
    logic                        wr_now;
    logic [NUM_BANKS*ADDR_W-1:0] rows_flat;
    logic [NUM_BANKS-1:0]        open_flat;
    logic                        ref_now;

    // Write data is masked in the same cycle as the mask; the command cycle is beat one.
    assign wr_now = run && !mask_now && dq_valid_s
                    && ((cmd == SDC_CMD_WRITE)
                        || (is_nop && burst_cnt_r > 8'h01 && bank_r[burst_bank_r] inside
                            {SDC_BANK_WRITE, SDC_BANK_WRAP}));
    assign ref_now = (run && cmd == SDC_CMD_REF) || (pwr_r == SDC_PWR_SELFREF);

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_flat
        assign rows_flat[g*ADDR_W +: ADDR_W] = row_r[g];
        assign open_flat[g] = (bank_r[g] != SDC_BANK_IDLE);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wr_strobe     <= 1'b0;
            wr_bank       <= '0;
            wr_col        <= '0;
            rd_drive_en   <= 1'b0;
            refresh_pulse <= 1'b0;
            refresh_row   <= ROW_RST;
            mode_reg      <= MODE_RST;
            open_rows     <= '0;
            bank_open     <= '0;
            pwr_state     <= SDC_PWR_RUN;
            all_idle      <= 1'b1;
        end else begin
            wr_strobe     <= wr_now;
            wr_bank       <= (cmd == SDC_CMD_WRITE) ? bank_sel : burst_bank_r;
            wr_col        <= (cmd == SDC_CMD_WRITE) ? addr_now[COL_W-1:0] : col_r;
            rd_drive_en   <= !mask_pipe_r[READ_MASK_LAT-1];
            refresh_pulse <= ref_now;
            refresh_row   <= ref_cnt_r;
            mode_reg      <= mode_r;
            open_rows     <= rows_flat;
            bank_open     <= open_flat;
            pwr_state     <= pwr_r;
            all_idle      <= banks_idle && (pwr_r == SDC_PWR_RUN);
        end
    end

endmodule : sdc_core

`default_nettype wire

/* sdc_core_assertions.sv */
// Concurrent checks on the outputs of the DRAM command and clock-gate block.
`timescale 1ns/100ps
`default_nettype none
module sdc_core_assertions
    import sdc_pkg::*;
#(
    parameter int BURST_LEN = BURST_LEN_DEF,
    parameter int EXIT_WAIT = EXIT_WAIT_DEF
) (
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 resetn,
    // Watched pins and outputs
    input wire logic                 byte_mask,
    input wire logic                 wr_strobe,
    input wire logic                 rd_drive_en,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [2:0]           pwr_state,
    input wire logic                 all_idle
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_IDLE_CLOSED: assert property (all_idle |-> bank_open == 4'h0 && pwr_state == 3'h0)
        else $error("all_idle while a bank is open or not running");
    AST_PDOWN_EXIT: assert property ($past(pwr_state) == 3'h1 && pwr_state == 3'h0 |-> ##[0:1] all_idle)
        else $error("power-down exit did not reach all banks idle");
    AST_SREXIT_WAIT: assert property (pwr_state == 3'h2 ##1 pwr_state != 3'h2 |-> pwr_state == 3'h4)
        else $error("self refresh left without the exit wait");
    AST_SREXIT_BOUND: assert property (pwr_state == 3'h4 |-> ##[1:8] pwr_state != 3'h4)
        else $error("self refresh exit wait never ends");
    AST_SELFREF_IDLE: assert property (pwr_state == 3'h2 |-> bank_open == 4'h0)
        else $error("self refresh with a bank open");
    AST_PDOWN_ENTRY: assert property (pwr_state == 3'h1 && $past(pwr_state) == 3'h0 |-> bank_open == 4'h0)
        else $error("power-down entered with a bank open");
    AST_SUSP_ENTRY: assert property (pwr_state == 3'h3 && $past(pwr_state) == 3'h0 |-> bank_open != 4'h0)
        else $error("clock suspend entered without an open bank");
    AST_WR_MASK: assert property (wr_strobe |-> !$past(byte_mask, 3))
        else $error("write beat stored while masked");
    AST_RD_MASK: assert property (byte_mask |-> ##5 !rd_drive_en)
        else $error("read data driven while masked");

    COV_SUSPEND: cover property (pwr_state == 3'h3);
    COV_SELFREF: cover property (pwr_state == 3'h2);
    COV_WRITE: cover property (wr_strobe);
endmodule : sdc_core_assertions

bind sdc_core sdc_core_assertions #(.BURST_LEN(BURST_LEN), .EXIT_WAIT(EXIT_WAIT)) i_chk (
    .clk_sys(clk_sys), .resetn(resetn), .byte_mask(byte_mask), .wr_strobe(wr_strobe),
    .rd_drive_en(rd_drive_en), .bank_open(bank_open), .pwr_state(pwr_state),
    .all_idle(all_idle));
`default_nettype wire

/* sdc_ctl_model.sv */
// Memory controller model that drives the command pins of the device.
`timescale 1ns/100ps
`default_nettype none
module sdc_ctl_model
    import sdc_pkg::*;
(
    // Clock
    input wire logic              clk_sys,
    // Command pins toward the device
    output var logic              clk_gate,
    output var logic              chip_sel_n,
    output var logic              row_strobe_n,
    output var logic              col_strobe_n,
    output var logic              write_strobe_n,
    output var logic              bank_select_low,
    output var logic              bank_select_high,
    output var logic [ADDR_W-1:0] addr,
    output var logic              byte_mask
);
    initial begin
        clk_gate = 1'b1;
        chip_sel_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_strobe_n} = 3'h7;
        {bank_select_high, bank_select_low} = 2'h0;
        addr = 12'h000;
        byte_mask = 1'b1;
    end

    // One command per edge; gate low only with refresh or no-op entries.
    task automatic drive(input sdc_cmd_t cmd, input logic [1:0] bank,
                         input logic [ADDR_W-1:0] a, input logic gate, input logic mask);
        logic [2:0] s;
        case (cmd)
            SDC_CMD_ACT:   s = 3'b011;
            SDC_CMD_READ:  s = 3'b101;
            SDC_CMD_WRITE: s = 3'b100;
            SDC_CMD_BST:   s = 3'b110;
            SDC_CMD_PRE:   s = 3'b010;
            SDC_CMD_REF:   s = 3'b001;
            SDC_CMD_LMR:   s = 3'b000;
            default:       s = 3'b111;
        endcase
        @(posedge clk_sys);
        chip_sel_n <= (cmd == SDC_CMD_INHIBIT);
        {row_strobe_n, col_strobe_n, write_strobe_n} <= s;
        {bank_select_high, bank_select_low} <= bank;
        // Unused address lines toggle so a stale value is never mistaken for a live one.
        addr <= (cmd == SDC_CMD_NOP || cmd == SDC_CMD_INHIBIT) ? ~addr : a;
        clk_gate <= gate;
        byte_mask <= mask;
    endtask : drive

    // Waiting periods are filled with no-ops, never stray commands.
    task automatic nops(input int n, input logic gate, input logic mask);
        repeat (n) drive(SDC_CMD_NOP, 2'h0, 12'h000, gate, mask);
    endtask : nops
endmodule : sdc_ctl_model
`default_nettype wire

/* sdc_core_bench.sv */
// Self-checking bench for the DRAM command and clock-gate block.
`timescale 1ns/100ps
`default_nettype none
module sdc_core_bench;
    import sdc_pkg::*;
    localparam int BL = 4;
    logic clk_sys, resetn, dq_in_valid, clk_gate, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi, mask;
    logic [ADDR_W-1:0] addr, refresh_row, mode_reg;
    logic wr_strobe, rd_drive_en, refresh_pulse, all_idle;
    logic [BANK_W-1:0] wr_bank, first_bank;
    logic [COL_W-1:0] wr_col, first_col;
    logic [NUM_BANKS*ADDR_W-1:0] open_rows;
    logic [NUM_BANKS-1:0] bank_open;
    logic [2:0] pwr_state;
    int n_fail, samples_checked, n_wr, n_ref, cycles;

    sdc_ctl_model i_ctl (.clk_sys(clk_sys), .clk_gate(clk_gate), .chip_sel_n(cs_n),
        .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_strobe_n(we_n),
        .bank_select_low(bs_lo), .bank_select_high(bs_hi), .addr(addr), .byte_mask(mask));
    sdc_core #(.BURST_LEN(BL), .EXIT_WAIT(2)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .clk_gate(clk_gate), .chip_sel_n(cs_n), .row_strobe_n(ras_n), .col_strobe_n(cas_n),
        .write_strobe_n(we_n), .bank_select_low(bs_lo), .bank_select_high(bs_hi),
        .addr(addr), .byte_mask(mask), .dq_in_valid(dq_in_valid), .wr_strobe(wr_strobe),
        .wr_bank(wr_bank), .wr_col(wr_col), .rd_drive_en(rd_drive_en),
        .refresh_pulse(refresh_pulse), .refresh_row(refresh_row), .mode_reg(mode_reg),
        .open_rows(open_rows), .bank_open(bank_open), .pwr_state(pwr_state),
        .all_idle(all_idle));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (refresh_pulse === 1'b1) n_ref++;
        if (wr_strobe === 1'b1) begin
            if (n_wr == 0) {first_bank, first_col} = {wr_bank, wr_col};
            n_wr++;
        end
        if (cycles == 3000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic cmd(input sdc_cmd_t c, input logic [1:0] b, input logic [11:0] a);
        i_ctl.drive(c, b, a, 1'b1, 1'b0);
        i_ctl.nops(8, 1'b1, 1'b0);
        #1;
    endtask : cmd

    task automatic t_mode_act();
        cmd(SDC_CMD_LMR, 2'h0, 12'ha5c);
        check("mode_reg", mode_reg, 12'ha5c);
        cmd(SDC_CMD_ACT, 2'h2, 12'h3c1);
        check("bank_open", bank_open, 4'h4);
        check("open_row", open_rows[24 +: 12], 12'h3c1);
    endtask : t_mode_act

    task automatic t_write();
        n_wr = 0;
        @(posedge clk_sys);
        dq_in_valid <= 1'b1;
        cmd(SDC_CMD_WRITE, 2'h2, 12'h017);
        check("beats", 48'(n_wr), 48'(BL));
        check("wr_target", {first_bank, first_col}, {2'h2, 8'h17});
        n_wr = 0;
        i_ctl.drive(SDC_CMD_WRITE, 2'h2, 12'h020, 1'b1, 1'b1);
        i_ctl.nops(8, 1'b1, 1'b1);
        #1;
        check("masked_beats", 48'(n_wr), 48'h0);
        check("rd_drive_en", rd_drive_en, 1'b0);
    endtask : t_write

    task automatic t_precharge();
        cmd(SDC_CMD_PRE, 2'h2, 12'h000);
        check("pre_one", bank_open, 4'h0);
        cmd(SDC_CMD_ACT, 2'h0, 12'h011);
        cmd(SDC_CMD_ACT, 2'h1, 12'h022);
        cmd(SDC_CMD_PRE, 2'h3, 12'h400);
        check("pre_all", bank_open, 4'h0);
        check("rd_drive_on", rd_drive_en, 1'b1);
        cmd(SDC_CMD_ACT, 2'h3, 12'h033);
        cmd(SDC_CMD_WRITE, 2'h3, 12'h410);
        check("auto_pre", bank_open, 4'h0);
    endtask : t_precharge

    task automatic t_cut();
        n_wr = 0;
        cmd(SDC_CMD_ACT, 2'h0, 12'h005);
        i_ctl.drive(SDC_CMD_WRITE, 2'h0, 12'h000, 1'b1, 1'b0);
        cmd(SDC_CMD_BST, 2'h0, 12'h000);
        check("bst_cut", n_wr < BL, 1'b1);
        i_ctl.drive(SDC_CMD_READ, 2'h0, 12'h000, 1'b1, 1'b0);
        cmd(SDC_CMD_PRE, 2'h0, 12'h000);
        check("read_pre", bank_open, 4'h0);
    endtask : t_cut

    task automatic t_refresh();
        logic [11:0] row0;
        n_ref = 0;
        row0 = refresh_row;
        cmd(SDC_CMD_REF, 2'h3, 12'hfff);
        check("auto_ref", 48'(n_ref), 48'h1);
        check("ref_row_moves", refresh_row != row0, 1'b1);
        i_ctl.drive(SDC_CMD_REF, 2'h0, 12'h000, 1'b0, 1'b0);
        i_ctl.nops(6, 1'b0, 1'b0);
        #1;
        check("selfref", pwr_state, 3'h2);
        i_ctl.nops(10, 1'b1, 1'b0);
        #1;
        check("selfref_exit", {pwr_state, all_idle}, 4'h1);
    endtask : t_refresh

    task automatic t_pdown();
        i_ctl.nops(6, 1'b0, 1'b0);
        #1;
        check("pdown", pwr_state, 3'h1);
        repeat (6) i_ctl.drive(SDC_CMD_INHIBIT, 2'h0, 12'h000, 1'b1, 1'b0);
        #1;
        check("pdown_exit", {pwr_state, all_idle}, 4'h1);
    endtask : t_pdown

    task automatic t_suspend();
        n_wr = 0;
        cmd(SDC_CMD_ACT, 2'h1, 12'h0aa);
        i_ctl.drive(SDC_CMD_WRITE, 2'h1, 12'h040, 1'b1, 1'b0);
        i_ctl.nops(5, 1'b0, 1'b0);
        #1;
        check("suspend", pwr_state, 3'h3);
        i_ctl.nops(8, 1'b1, 1'b0);
        #1;
        check("resumed", {pwr_state, 29'(n_wr)}, {3'h0, 29'(BL)});
        cmd(SDC_CMD_PRE, 2'h1, 12'h000);
    endtask : t_suspend

    initial begin
        {n_fail, samples_checked, n_wr, n_ref, cycles} = '0;
        resetn = 1'b0;
        dq_in_valid = 1'b0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        check("reset", {pwr_state, all_idle, bank_open, mode_reg}, {3'h0, 1'b1, 16'h0});
        t_mode_act();
        t_write();
        t_precharge();
        t_cut();
        t_refresh();
        t_pdown();
        t_suspend();
        give_verdict();
    end
endmodule : sdc_core_bench
`default_nettype wire
